// *** lsfm_top.sv ***
// Fault monitor for four high-side lamp channels.
// Comparator inputs are asynchronous and are synchronised here; the
// command and pull-up enable bits come from logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "lsfm_cfg.svh"

// ==============================================================
// What this block does
// - Four independent channels, each with own state, short flag and open-load flag.
// - Short still present when switch-on delay expires switches off, sets flag.
// - Switch-on short means overcurrent together with output voltage still low.
// - On-state overcurrent longer than short delay switches off, sets flag.
// - Off channel flags open load when output rises above threshold, within delay.
// - Open-load flag latched until status reset command or power-on reset.
// - Pull-up current enabled only while the channel's pull-up enable bit is high.
// - After short shutdown, channel stays off and flagged until status reset.
module lsfm_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire lsfm_pkg::lsfm_ch_t channel_on_cmd,
	input wire lsfm_pkg::lsfm_ch_t open_load_pullup_enable,
	input wire logic status_reset,
	input wire lsfm_pkg::lsfm_cmp_s [`LSFM_CHANNELS-1:0] comparators,
	output logic [`LSFM_CHANNELS-1:0] switch_on,
	output logic [`LSFM_CHANNELS-1:0] pullup_on,
	output logic [`LSFM_CHANNELS-1:0] short_flag,
	output logic [`LSFM_CHANNELS-1:0] open_load_flag
);
	import lsfm_pkg::*;

	localparam lsfm_cnt_t SW_ON_CYC = lsfm_cnt_t'(`LSFM_SW_ON_DLY_CYC);
	localparam lsfm_cnt_t ON_CYC = lsfm_cnt_t'(`LSFM_ON_DLY_CYC);

	lsfm_state_s st_r;
	lsfm_state_s st_nxt;

	// ==============================================================
	// Per-channel protection
	// The switch-on check waits the least qualification time; a short that
	// clears earlier lets the channel proceed to the on-state check.
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < `LSFM_CHANNELS; i++) begin
			st_nxt.ch[i].sync1 = comparators[i];
			st_nxt.ch[i].sync2 = st_r.ch[i].sync1;
			case (st_r.ch[i].state)
				LSFM_OFF: begin
					st_nxt.ch[i].cnt = '0;
					if (channel_on_cmd[i]) begin
						st_nxt.ch[i].state = LSFM_STARTING;
					end
				end
				LSFM_STARTING: begin
					st_nxt.ch[i].cnt = st_r.ch[i].cnt + lsfm_cnt_t'(1);
					if (!channel_on_cmd[i]) begin
						st_nxt.ch[i].state = LSFM_OFF;
					end else if (st_r.ch[i].cnt >= SW_ON_CYC - lsfm_cnt_t'(1)) begin
						if (st_r.ch[i].sync2.overcurrent && st_r.ch[i].sync2.short_voltage_low) begin
							st_nxt.ch[i].state = LSFM_TRIPPED;
							st_nxt.ch[i].short_flag = 1'b1;
						end else begin
							st_nxt.ch[i].state = LSFM_ON;
							st_nxt.ch[i].cnt = '0;
						end
					end
				end
				LSFM_ON: begin
					if (!channel_on_cmd[i]) begin
						st_nxt.ch[i].state = LSFM_OFF;
					end else if (st_r.ch[i].sync2.overcurrent) begin
						st_nxt.ch[i].cnt = st_r.ch[i].cnt + lsfm_cnt_t'(1);
						if (st_r.ch[i].cnt >= ON_CYC - lsfm_cnt_t'(1)) begin
							st_nxt.ch[i].state = LSFM_TRIPPED;
							st_nxt.ch[i].short_flag = 1'b1;
						end
					end else begin
						st_nxt.ch[i].cnt = '0;
					end
				end
				LSFM_TRIPPED: begin
					st_nxt.ch[i].cnt = '0;
					if (status_reset) begin
						st_nxt.ch[i].state = LSFM_OFF;
					end
				end
				default: begin
					st_nxt.ch[i].state = LSFM_OFF;
				end
			endcase
			// Status reset clears only if no new short is set this cycle.
			if (status_reset && st_nxt.ch[i].state != LSFM_TRIPPED) begin
				st_nxt.ch[i].short_flag = 1'b0;
			end
			// The open-load comparator is trusted only while the switch is off.
			if (status_reset) begin
				st_nxt.ch[i].open_load_flag = 1'b0;
			end
			if (st_r.ch[i].state == LSFM_OFF && st_r.ch[i].sync2.above_open_load) begin
				st_nxt.ch[i].open_load_flag = 1'b1;
			end
			st_nxt.ch[i].switch_on = (st_nxt.ch[i].state == LSFM_STARTING || st_nxt.ch[i].state == LSFM_ON)
				&& !st_nxt.ch[i].short_flag;
			st_nxt.ch[i].pullup_on = open_load_pullup_enable[i] && st_nxt.ch[i].state == LSFM_OFF;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==============================================================
	// Outputs
	generate
		for (genvar g = 0; g < `LSFM_CHANNELS; g++) begin : g_out
			assign switch_on[g] = st_r.ch[g].switch_on;
			assign pullup_on[g] = st_r.ch[g].pullup_on;
			assign short_flag[g] = st_r.ch[g].short_flag;
			assign open_load_flag[g] = st_r.ch[g].open_load_flag;
		end
	endgenerate

	// ==============================================================
	// Checks on channel 0
	// All channels share one body of logic, so channel 0 stands for the others.

	property p_trip_off;
		@(posedge core_clk) disable iff (rst)
		$rose(short_flag[0]) |-> !switch_on[0];
	endproperty
	a_trip_off: assert property (p_trip_off)
		else $error("Switch on while short flagged.");

	property p_start_short;
		@(posedge core_clk) disable iff (rst)
		st_r.ch[0].state == LSFM_STARTING && channel_on_cmd[0] && st_r.ch[0].cnt == SW_ON_CYC - 1
		&& st_r.ch[0].sync2.overcurrent && st_r.ch[0].sync2.short_voltage_low |=> short_flag[0];
	endproperty
	a_start_short: assert property (p_start_short)
		else $error("Switch-on short not flagged.");

	property p_start_needs_low;
		@(posedge core_clk) disable iff (rst)
		st_r.ch[0].state == LSFM_STARTING && !st_r.ch[0].sync2.short_voltage_low && !short_flag[0]
		&& !status_reset |=> !short_flag[0];
	endproperty
	a_start_needs_low: assert property (p_start_needs_low)
		else $error("Switch-on trip without low voltage.");

	property p_on_short;
		@(posedge core_clk) disable iff (rst)
		st_r.ch[0].state == LSFM_ON && channel_on_cmd[0] && st_r.ch[0].sync2.overcurrent
		&& st_r.ch[0].cnt == ON_CYC - 1 |=> short_flag[0] && !switch_on[0];
	endproperty
	a_on_short: assert property (p_on_short)
		else $error("On-state short not handled.");

	property p_open_load;
		@(posedge core_clk) disable iff (rst)
		st_r.ch[0].state == LSFM_OFF && comparators[0].above_open_load [*3] |-> ##[1:4] open_load_flag[0];
	endproperty
	a_open_load: assert property (p_open_load)
		else $error("Open load not flagged.");

	property p_ol_hold;
		@(posedge core_clk) disable iff (rst)
		open_load_flag[0] && !status_reset |=> open_load_flag[0];
	endproperty
	a_ol_hold: assert property (p_ol_hold)
		else $error("Open-load flag lost.");

	property p_pullup;
		@(posedge core_clk) disable iff (rst)
		!open_load_pullup_enable[0] |=> !pullup_on[0];
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("Pull-up on while disabled.");

	property p_trip_hold;
		@(posedge core_clk) disable iff (rst)
		short_flag[0] && !status_reset |=> short_flag[0] && !switch_on[0];
	endproperty
	a_trip_hold: assert property (p_trip_hold)
		else $error("Short fault released early.");

	property p_start_early;
		@(posedge core_clk) disable iff (rst)
		st_r.ch[0].state == LSFM_STARTING && st_r.ch[0].cnt < SW_ON_CYC - 1 |=> !short_flag[0];
	endproperty
	a_start_early: assert property (p_start_early)
		else $error("Switch-on short flagged before the delay ran out.");

	property p_cmd_off;
		@(posedge core_clk) disable iff (rst)
		!channel_on_cmd[0] |=> !switch_on[0];
	endproperty
	a_cmd_off: assert property (p_cmd_off)
		else $error("Switch on without command.");

	property p_pullup_idle;
		@(posedge core_clk) disable iff (rst)
		open_load_pullup_enable[0] && !channel_on_cmd[0] && st_r.ch[0].state == LSFM_OFF |=> pullup_on[0];
	endproperty
	a_pullup_idle: assert property (p_pullup_idle)
		else $error("Pull-up off while enabled on an idle channel.");

	// A fresh open-load event in the clearing cycle wins, so it is left out here.
	property p_ol_clear;
		@(posedge core_clk) disable iff (rst)
		status_reset && !(st_r.ch[0].state == LSFM_OFF && st_r.ch[0].sync2.above_open_load)
		|=> !open_load_flag[0];
	endproperty
	a_ol_clear: assert property (p_ol_clear)
		else $error("Open-load flag not cleared by status reset.");

	property p_trip_clear;
		@(posedge core_clk) disable iff (rst)
		status_reset && st_r.ch[0].state == LSFM_TRIPPED |=> !short_flag[0] && !switch_on[0];
	endproperty
	a_trip_clear: assert property (p_trip_clear)
		else $error("Short fault not released by status reset.");

	cover property (@(posedge core_clk) disable iff (rst) $rose(switch_on[0]));
	cover property (@(posedge core_clk) disable iff (rst) $rose(short_flag[0]));
	cover property (@(posedge core_clk) disable iff (rst) $rose(open_load_flag[0]));
	cover property (@(posedge core_clk) disable iff (rst) status_reset && short_flag[0]);
endmodule : lsfm_top

`default_nettype wire

// *** lsfm_cfg.svh ***
// Timing constants for the lamp switch fault monitor.
// Assumes a 20 MHz core clock; cycle counts follow from the times in microseconds.
`ifndef LSFM_CFG_SVH
`define LSFM_CFG_SVH

`define LSFM_CLK_MHZ 20
`define LSFM_CHANNELS 4
// Switch-on qualification delay, microseconds (least 125, most 350).
`define LSFM_SW_ON_DLY_US 125
`define LSFM_SW_ON_DLY_CYC (`LSFM_SW_ON_DLY_US * `LSFM_CLK_MHZ)
// On-state short delay, microseconds (least 10, most 60).
`define LSFM_ON_DLY_US 10
`define LSFM_ON_DLY_CYC (`LSFM_ON_DLY_US * `LSFM_CLK_MHZ)
// Open-load detection, longest delay in microseconds.
`define LSFM_OL_DLY_US 200
`define LSFM_OL_DLY_CYC (`LSFM_OL_DLY_US * `LSFM_CLK_MHZ)
`define LSFM_CNT_W 13

`endif

// *** lsfm_pkg.sv ***
// Types for the lamp switch fault monitor.
// Assumes lsfm_cfg.svh is on the include path.
`default_nettype none
`include "lsfm_cfg.svh"

package lsfm_pkg;
	typedef logic [`LSFM_CHANNELS-1:0] lsfm_ch_t;
	typedef logic [`LSFM_CNT_W-1:0] lsfm_cnt_t;

	typedef enum logic [1:0] {
		LSFM_OFF = 2'b00,
		LSFM_STARTING = 2'b01,
		LSFM_ON = 2'b10,
		LSFM_TRIPPED = 2'b11
	} lsfm_state_e;

	typedef struct packed {
		logic overcurrent;
		logic short_voltage_low;
		logic above_open_load;
	} lsfm_cmp_s;

	typedef struct packed {
		lsfm_state_e state;
		lsfm_cnt_t cnt;
		logic short_flag;
		logic open_load_flag;
		logic switch_on;
		logic pullup_on;
		lsfm_cmp_s sync1;
		lsfm_cmp_s sync2;
	} lsfm_chan_s;

	typedef struct packed {
		lsfm_chan_s [`LSFM_CHANNELS-1:0] ch;
	} lsfm_state_s;
endpackage : lsfm_pkg

`default_nettype wire

// *** lsfm_load.sv ***
// Lamp load model facing the four lamp channels of the fault monitor.
// Assumes lsfm_pkg is compiled first; comparators follow the drive at once.
`timescale 1ns/100ps
`default_nettype none
// ==============================================================
// Load model
module lsfm_load (
	input wire logic [3:0] switch_on,
	input wire logic [3:0] pullup_on,
	input wire logic [7:0] mode,
	output var lsfm_pkg::lsfm_cmp_s [3:0] comparators
);
	import lsfm_pkg::*;
	// Mode 1 is a short to ground, 2 an open load, 3 a cold lamp whose inrush trips only the current comparator.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			comparators[i].overcurrent = switch_on[i] && (mode[2*i+:2] == 2'h1 || mode[2*i+:2] == 2'h3);
			comparators[i].short_voltage_low = !switch_on[i] || mode[2*i+:2] == 2'h1;
			comparators[i].above_open_load = !switch_on[i] && pullup_on[i] && mode[2*i+:2] == 2'h2;
		end
	end
endmodule : lsfm_load
`default_nettype wire

// *** lsfm_top_test.sv ***
// Self-checking bench for the lamp switch fault monitor.
// Assumes lsfm_pkg, lsfm_top and lsfm_load are compiled before it.
`timescale 1ns/100ps
`default_nettype none
// ==============================================================
// Bench
module lsfm_top_test;
	import lsfm_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic status_reset = 1'b0;
	lsfm_ch_t cmd = 4'h0;
	lsfm_ch_t pen = 4'h0;
	logic [7:0] mode = 8'h0;
	logic [31:0] r;
	lsfm_cmp_s [3:0] cmp;
	logic [3:0] sw, pu, sf, olf;
	int failures = 0;
	int cmp_count = 0;
	int seed = 32'hA845;
	always #25 core_clk = ~core_clk;
	lsfm_top u_dut (.core_clk(core_clk), .rst(rst), .channel_on_cmd(cmd), .open_load_pullup_enable(pen),
		.status_reset(status_reset), .comparators(cmp), .switch_on(sw), .pullup_on(pu), .short_flag(sf),
		.open_load_flag(olf));
	lsfm_load u_load (.switch_on(sw), .pullup_on(pu), .mode(mode), .comparators(cmp));
	function automatic logic [3:0] exp_pullup(input logic [3:0] en, input logic [3:0] on, input logic [3:0] trip);
		return en & ~on & ~trip;
	endfunction : exp_pullup
	task automatic check(input logic [3:0] seen, input logic [3:0] want);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic test_done;
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	// The run needs about 3000 cycles; the limit leaves ample margin.
	initial begin
		#500000;
		failures++;
		test_done();
	end
	initial begin
		tick(16);
		check(sw | pu | sf | olf, 4'h0);
		rst = 1'b0;
		// Channel 0 shorted, 1 a cold lamp, 2 open, 3 open but an LED with the pull-up kept off.
		mode = 8'hAD;
		pen = 4'h7;
		cmd = 4'h3;
		tick(4);
		check(sw, 4'h3);
		check(pu, exp_pullup(pen, cmd, 4'h0));
		check(olf, 4'h4);
		tick(2390);
		check(sf, 4'h0);
		tick(150);
		check(sf, 4'h1);
		check(sw, 4'h2);
		tick(100);
		check(sf, 4'h1);
		tick(100);
		check(sf, 4'h3);
		check(sw, 4'h0);
		mode = 8'h4D;
		tick(50);
		check(sw, 4'h0);
		check(sf, 4'h3);
		check(olf, 4'h4);
		status_reset = 1'b1;
		tick(1);
		status_reset = 1'b0;
		tick(2);
		check(sf | olf, 4'h0);
		check(sw, 4'h3);
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			cmd = r[3:0];
			pen = r[7:4];
			tick(3);
			check(pu, exp_pullup(pen, cmd, 4'h0));
			check(sw, cmd);
		end
		// An open load still present while status reset is pulsed keeps its flag.
		cmd = 4'h0;
		pen = 4'h4;
		mode = 8'h20;
		tick(6);
		check(olf, 4'h4);
		status_reset = 1'b1;
		tick(1);
		status_reset = 1'b0;
		tick(2);
		check(olf, 4'h4);
		check(sw, 4'h0);
		test_done();
	end
endmodule : lsfm_top_test
`default_nettype wire
